/* inc/compact_timer_pkg.sv */
package compact_timer_pkg;

	// ****************************************************
	// Register byte addresses on the bus.
	// ****************************************************
	localparam logic [7:0] OFS_CTRL_A = 8'h00; // Control A.
	localparam logic [7:0] OFS_CTRL_B = 8'h04; // Control B.
	localparam logic [7:0] OFS_CNT_LO = 8'h08; // Counter low.
	localparam logic [7:0] OFS_CNT_HI = 8'h0C; // Counter high.
	localparam logic [7:0] OFS_CMPA_LO = 8'h10; // Compare A low.
	localparam logic [7:0] OFS_CMPA_HI = 8'h14; // Compare A high.
	localparam logic [7:0] OFS_PERIOD = 8'h18; // Compare P.

	// ****************************************************
	// Reset values.
	// ****************************************************
	localparam logic [7:0] CTRL_RST = 8'h00; // Both controls.
	localparam logic [7:0] DATA_RST = 8'h00; // Data bytes.
	localparam logic [15:0] CNT_RST = 16'h0000; // Counter.

	// ****************************************************
	// Timing: core rate and low-speed clock rate.
	// ****************************************************
	localparam int CLK_HZ = 20000000; // Core clock in Hz.
	localparam int SUB_HZ = 32768; // Low-speed clock in Hz.
	localparam int SUB_DIV = CLK_HZ / SUB_HZ; // Cycles per tick.

	// Clock source select codes.
	typedef enum logic [2:0] {
		SRC_SYS_DIV4 = 3'h0,
		SRC_SYS = 3'h1,
		SRC_HS_DIV16 = 3'h2,
		SRC_HS_DIV64 = 3'h3,
		SRC_SUB_A = 3'h4,
		SRC_SUB_B = 3'h5,
		SRC_EXT_RISE = 3'h6,
		SRC_EXT_FALL = 3'h7
	} clk_sel_t;

	// Operating modes.
	typedef enum logic [1:0] {
		MODE_CMP = 2'h0,
		MODE_UNDEF = 2'h1,
		MODE_PWM = 2'h2,
		MODE_TMR = 2'h3
	} mode_t;

	// Control A layout, low three bits reserved.
	typedef struct packed {
		logic pause_control;
		clk_sel_t clock_source_select;
		logic counter_on;
		logic [2:0] rsv;
	} ctrl_a_t;

	// Control B layout.
	typedef struct packed {
		mode_t operating_mode_field;
		logic [1:0] pin_function_field;
		logic output_initial_level;
		logic output_invert;
		logic duty_period_swap;
		logic clear_source_select;
	} ctrl_b_t;

endpackage : compact_timer_pkg

/* hdl/compact_timer_pwm.sv */
`timescale 1ns/1ps
module compact_timer_pwm
	import compact_timer_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic external_clock_pin_i,
	output logic timer_output_pin_o,
	output logic timer_output_oe_o,
	output logic compare_a_flag_o,
	output logic compare_p_flag_o
);

	// ****************************************************
	// Storage.
	// ****************************************************
	ctrl_a_t ctrl_a_ff; // Pause, clock select, enable.
	ctrl_b_t ctrl_b_ff; // Mode and pin control.
	logic [15:0] cnt_ff; // The counter itself.
	logic [15:0] cmpa_ff; // Compare A value.
	logic [7:0] cmpp_ff; // Compare P value.
	logic [7:0] buf_ff; // Shared low-byte holding buffer.
	logic on_d_ff; // Enable bit one cycle late.
	logic [5:0] div_ff; // Free divider for ratio clocks.
	logic [9:0] sub_ff; // Divider for the low-speed rate.
	logic ext_s1_ff; // Synchroniser first stage.
	logic ext_s2_ff; // Synchroniser second stage.
	logic ext_s3_ff; // Edge detector history.
	logic lvl_ff; // Output level before inversion.
	logic ack_ff; // Bus answer.

	// ****************************************************
	// Shared arithmetic.
	// ****************************************************
	// Match of the next count against a full word.
	function automatic logic word_hit(input logic [16:0] nv,
		input logic [15:0] val);
		word_hit = (val != 16'h0000) && (nv[15:0] == val);
	endfunction : word_hit

	default clocking dc @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ****************************************************
	// Bus decode.
	// ****************************************************
	logic req; // A new request not yet answered.
	logic wr; // Write with the low byte lane enabled.
	logic rd; // Read taken this cycle.
	assign req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign rd = req && !wb_we_i;

	// Answer one cycle after the strobe; drop it next cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req;
		end
	end
	assign wb_ack_o = ack_ff;

	// Read data is captured with the answer, so it stays
	// valid for exactly the cycle in which ack is high.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (rd) begin
			case (wb_adr_i)
				OFS_CTRL_A: wb_dat_o <= {24'h000000,
					ctrl_a_ff[7:3], 3'h0};
				OFS_CTRL_B: wb_dat_o <= {24'h000000, ctrl_b_ff};
				OFS_CNT_LO: wb_dat_o <= {24'h000000, buf_ff};
				OFS_CNT_HI: wb_dat_o <= {24'h000000, cnt_ff[15:8]};
				OFS_CMPA_LO: wb_dat_o <= {24'h000000, buf_ff};
				OFS_CMPA_HI: wb_dat_o <= {24'h000000,
					cmpa_ff[15:8]};
				OFS_PERIOD: wb_dat_o <= {24'h000000, cmpp_ff};
				default: wb_dat_o <= 32'h00000000;
			endcase
		end else begin
			wb_dat_o <= 32'h00000000;
		end
	end

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");
	a_rsv_zero: assert property (
		rd && wb_adr_i == OFS_CTRL_A |=> wb_dat_o[2:0] == 3'h0)
		else $error("reserved control bits read nonzero");

	// ****************************************************
	// Control and compare registers.
	// ****************************************************
	// Mode changes while running are the writer's hazard;
	// the logic simply follows the new value.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_a_ff <= ctrl_a_t'(CTRL_RST);
			ctrl_b_ff <= ctrl_b_t'(CTRL_RST);
			cmpp_ff <= DATA_RST;
		end else if (wr) begin
			case (wb_adr_i)
				OFS_CTRL_A: ctrl_a_ff <= ctrl_a_t'({wb_dat_i[7:3],
					3'h0});
				OFS_CTRL_B: ctrl_b_ff <= ctrl_b_t'(wb_dat_i[7:0]);
				OFS_PERIOD: cmpp_ff <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	// Compare A is written as a pair so both halves change
	// together and the comparator never sees a torn value.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmpa_ff <= CNT_RST;
		end else if (wr && wb_adr_i == OFS_CMPA_HI) begin
			cmpa_ff <= {wb_dat_i[7:0], buf_ff};
		end
	end

	// Holding buffer: filled by compare A low writes or high reads.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buf_ff <= DATA_RST;
		end else if (wr && wb_adr_i == OFS_CMPA_LO) begin
			buf_ff <= wb_dat_i[7:0];
		end else if (rd && wb_adr_i == OFS_CNT_HI) begin
			buf_ff <= cnt_ff[7:0];
		end else if (rd && wb_adr_i == OFS_CMPA_HI) begin
			buf_ff <= cmpa_ff[7:0];
		end
	end

	a_pair_load: assert property (
		wr && wb_adr_i == OFS_CMPA_HI |=>
		cmpa_ff == {$past(wb_dat_i[7:0]), $past(buf_ff)})
		else $error("compare A pair not loaded from buffer");
	a_cnt_latch: assert property (
		rd && wb_adr_i == OFS_CNT_HI |=> buf_ff == $past(cnt_ff[7:0]))
		else $error("counter low byte not latched");

	// ****************************************************
	// Clock source enables.
	// ****************************************************
	// Ratio clocks are one-cycle enables from free dividers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_ff <= 6'h00;
			sub_ff <= 10'h000;
		end else begin
			div_ff <= div_ff + 6'h01;
			if (sub_ff == 10'(SUB_DIV - 1)) begin
				sub_ff <= 10'h000;
			end else begin
				sub_ff <= sub_ff + 10'h001;
			end
		end
	end

	// Two stages before any logic looks at the pin.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
			ext_s3_ff <= 1'b0;
		end else begin
			ext_s1_ff <= external_clock_pin_i;
			ext_s2_ff <= ext_s1_ff;
			ext_s3_ff <= ext_s2_ff;
		end
	end

	logic src_en; // Selected clock source ticks now.
	always_comb begin
		case (ctrl_a_ff.clock_source_select)
			SRC_SYS_DIV4: src_en = (div_ff[1:0] == 2'h3);
			SRC_SYS: src_en = 1'b1;
			SRC_HS_DIV16: src_en = (div_ff[3:0] == 4'hF);
			SRC_HS_DIV64: src_en = (div_ff == 6'h3F);
			SRC_SUB_A, SRC_SUB_B: src_en = (sub_ff == 10'h000);
			SRC_EXT_RISE: src_en = ext_s2_ff && !ext_s3_ff;
			SRC_EXT_FALL: src_en = !ext_s2_ff && ext_s3_ff;
			default: src_en = 1'b0;
		endcase
	end

	a_ext_edge: assert property (
		ctrl_a_ff.clock_source_select == SRC_EXT_RISE &&
		ext_s2_ff && !ext_s3_ff |-> src_en)
		else $error("external rising edge not taken");

	// ****************************************************
	// Counter and comparators.
	// ****************************************************
	logic on_rise; // Enable bit went low to high.
	logic tick; // Counter advances this cycle.
	logic [16:0] nv; // Next count with carry.
	logic match_a; // Comparator A hit on this tick.
	logic match_p; // Comparator P hit on this tick.
	logic ovf; // Counter wraps on this tick.
	logic is_pwm; // PWM mode selected.
	logic clr; // Clear instead of increment.
	assign on_rise = ctrl_a_ff.counter_on && !on_d_ff;
	assign tick = ctrl_a_ff.counter_on &&
		!ctrl_a_ff.pause_control && src_en;
	assign nv = {1'b0, cnt_ff} + 17'h00001;
	assign match_a = tick && word_hit(nv, cmpa_ff);
	assign match_p = tick && word_hit(nv, {cmpp_ff, 8'h00});
	assign ovf = tick && nv[16];
	assign is_pwm = ctrl_b_ff.operating_mode_field == MODE_PWM;
	// Overflow wraps to zero by itself, covering a zero P.
	assign clr = is_pwm ?
		(ctrl_b_ff.duty_period_swap ? match_a : match_p) :
		(ctrl_b_ff.clear_source_select ? match_a : match_p);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			on_d_ff <= 1'b0;
		end else begin
			on_d_ff <= ctrl_a_ff.counter_on;
		end
	end

	// Software only clears the count via the enable edge.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= CNT_RST;
		end else if (on_rise) begin
			cnt_ff <= CNT_RST;
		end else if (tick) begin
			cnt_ff <= clr ? CNT_RST : nv[15:0];
		end
	end

	a_on_clear: assert property (
		on_rise |=> cnt_ff == CNT_RST)
		else $error("enable rise did not clear counter");
	a_pause_hold: assert property (
		ctrl_a_ff.pause_control && !on_rise |=> $stable(cnt_ff))
		else $error("counter moved while paused");
	a_a_clear: assert property (
		!is_pwm && ctrl_b_ff.clear_source_select && match_a &&
		!on_rise |=> cnt_ff == CNT_RST)
		else $error("compare A match did not clear counter");

	// ****************************************************
	// Request pulses.
	// ****************************************************
	// A-clearing compare mode suppresses the P request.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			compare_a_flag_o <= 1'b0;
			compare_p_flag_o <= 1'b0;
		end else begin
			compare_a_flag_o <= match_a;
			compare_p_flag_o <= (match_p || (ovf && cmpp_ff == 8'h00)) &&
				(is_pwm || !ctrl_b_ff.clear_source_select);
		end
	end

	a_no_p_flag: assert property (
		!is_pwm && ctrl_b_ff.clear_source_select |=> !compare_p_flag_o)
		else $error("P request raised while A clears");

	// ****************************************************
	// Output pin.
	// ****************************************************
	logic drive; // Compare or PWM mode drives the pin.
	logic duty_on; // PWM waveform in its active part.
	logic nxt_lvl; // Next level before inversion.
	assign drive = is_pwm ||
		ctrl_b_ff.operating_mode_field == MODE_CMP;
	assign duty_on = ctrl_b_ff.duty_period_swap ?
		(cnt_ff[15:8] < cmpp_ff) : (cnt_ff < cmpa_ff);

	// The level in compare mode is state; in PWM pin function 2 follows
	// the count each cycle, one cycle behind the counter.
	always_comb begin
		nxt_lvl = lvl_ff;
		if (drive && on_rise) begin
			nxt_lvl = ctrl_b_ff.output_initial_level;
		end else if (is_pwm) begin
			case (ctrl_b_ff.pin_function_field)
				2'h0: nxt_lvl = !ctrl_b_ff.output_initial_level;
				2'h1: nxt_lvl = ctrl_b_ff.output_initial_level;
				2'h2: nxt_lvl = duty_on ?
					ctrl_b_ff.output_initial_level :
					!ctrl_b_ff.output_initial_level;
				default: nxt_lvl = lvl_ff;
			endcase
		end else if (drive && match_a) begin
			case (ctrl_b_ff.pin_function_field)
				2'h1: nxt_lvl = 1'b0;
				2'h2: nxt_lvl = 1'b1;
				2'h3: nxt_lvl = !lvl_ff;
				default: nxt_lvl = lvl_ff;
			endcase
		end
	end

	// Pin and enable are registered; timer mode floats it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_ff <= 1'b0;
			timer_output_pin_o <= 1'b0;
			timer_output_oe_o <= 1'b0;
		end else begin
			lvl_ff <= nxt_lvl;
			timer_output_pin_o <= nxt_lvl ^ ctrl_b_ff.output_invert;
			timer_output_oe_o <= drive;
		end
	end

	a_pin_init: assert property (
		drive && on_rise |=> timer_output_pin_o ==
		($past(ctrl_b_ff.output_initial_level) ^
		$past(ctrl_b_ff.output_invert)))
		else $error("pin not reset to initial level");
	a_timer_float: assert property (
		ctrl_b_ff.operating_mode_field == MODE_TMR |=>
		!timer_output_oe_o)
		else $error("pin driven in timer mode");

endmodule : compact_timer_pwm

/* sim/compact_timer_pwm_tb.sv */
`timescale 1ns/1ps
module compact_timer_pwm_tb;
	import compact_timer_pkg::*;
	// ****************************************************
	// Design ports, bench state and the register model.
	// ****************************************************
	logic clk_i = 1'b0; // Core clock, 50 ns period.
	logic rst_i = 1'b1; // Reset, held at start.
	logic wb_cyc_i = 1'b0; // Bus cycle.
	logic wb_stb_i = 1'b0; // Bus strobe.
	logic wb_we_i = 1'b0; // Bus direction.
	logic [7:0] wb_adr_i = 8'h00; // Bus address.
	logic [3:0] wb_sel_i = 4'h0; // Byte select.
	logic [31:0] wb_dat_i = 32'h00000000; // Write data.
	logic external_clock_pin_i = 1'b0; // External count clock.
	logic [31:0] wb_dat_o; // Read data.
	logic wb_ack_o; // Bus acknowledge.
	logic timer_output_pin_o; // Output pin level.
	logic timer_output_oe_o; // Output pin enable.
	logic compare_a_flag_o; // Comparator A event.
	logic compare_p_flag_o; // Comparator P event.
	int n_fail = 0; // Mismatches seen.
	int cmp_count = 0; // Comparisons made.
	int seed = 76034; // Fixed seed for repeatable runs.
	int mdl [8]; // Model of the register bytes.
	int mbuf = 0; // Model of the shared low-byte buffer.
	int p_cnt = 0; // Comparator P pulses seen so far.
	int k; // Loop index.
	int n; // Scratch count.
	int m; // Measured interval.
	logic [2:0] kb; // Loop index as bits.
	logic lv; // Remembered pin level.
	logic [31:0] q; // Last read data.
	logic [15:0] cv; // Last counter value.

	// Free-running clock.
	always #25 clk_i = ~clk_i;

	// Count P pulses, so silent periods can be proven silent.
	always @(posedge clk_i) begin
		if (compare_p_flag_o === 1'b1) begin
			p_cnt <= p_cnt + 1;
		end
	end

	compact_timer_pwm compact_timer_pwm_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .external_clock_pin_i(external_clock_pin_i),
		.timer_output_pin_o(timer_output_pin_o),
		.timer_output_oe_o(timer_output_oe_o),
		.compare_a_flag_o(compare_a_flag_o),
		.compare_p_flag_o(compare_p_flag_o)
	);

	// ****************************************************
	// Verdict and comparisons.
	// ****************************************************
	task finish_test;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	// Register bytes: upper read bits must be zero as well.
	task cmp_byte(input string nm, input logic [7:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== {24'h000000, e}) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_byte

	// Counts and intervals.
	task cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %0d seen %0d", nm, e, g);
		end
	endtask : cmp_val

	// Pin levels.
	task cmp_bit(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit

	// ****************************************************
	// Bus cycles and waits.
	// ****************************************************
	// One classic cycle; the request stands until ack is sampled.
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {24'h000000, d};
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 16);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			n_fail++;
			finish_test();
		end
	endtask : wb

	// Write a byte and track it in the model.
	task wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d, 4'h1);
		case (a)
			OFS_CTRL_A: mdl[0] = d & 8'hF8;
			OFS_CMPA_LO: mbuf = d;
			OFS_CMPA_HI: begin
				mdl[5] = d;
				mdl[4] = mbuf;
			end
			OFS_CTRL_B, OFS_PERIOD: mdl[a[4:2]] = d;
			default: ; // Counter and unmapped places ignore writes.
		endcase
	endtask : wr

	// Read a register and compare it with the model.
	task rd_chk(input logic [7:0] a);
		int e;
		wb(1'b0, a, 8'h00, 4'h1);
		e = (a > OFS_PERIOD) ? 0 : mdl[a[4:2]];
		if (a == OFS_CMPA_HI) begin
			mbuf = mdl[4];
		end
		if (a == OFS_CMPA_LO) begin
			e = mbuf;
		end
		cmp_byte("register", 8'(e), q);
	endtask : rd_chk

	// High byte first, so the low byte comes from the same instant.
	task rdcnt;
		wb(1'b0, OFS_CNT_HI, 8'h00, 4'h1);
		cv[15:8] = q[7:0];
		wb(1'b0, OFS_CNT_LO, 8'h00, 4'h1);
		cv[7:0] = q[7:0];
		mbuf = cv[7:0];
	endtask : rdcnt

	// Wait some edges, then settle past the last one so that
	// outputs launched at that edge are read after they land.
	task ticks(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask : ticks

	// Wait for a flag pulse; sampled after the edge has settled.
	task wait_flag(input bit w);
		int i;
		i = 0;
		do begin
			@(posedge clk_i);
			#1;
			i++;
		end while ((w ? compare_p_flag_o : compare_a_flag_o) !== 1'b1
			&& i < 2000);
		if (i >= 2000) begin
			n_fail++;
			finish_test();
		end
	endtask : wait_flag

	// Cycles from one flag pulse to the next.
	task gap(input bit w, output int c);
		wait_flag(w);
		c = 0;
		do begin
			@(posedge clk_i);
			#1;
			c++;
		end while ((w ? compare_p_flag_o : compare_a_flag_o) !== 1'b1
			&& c < 2000);
	endtask : gap

	// Cycles at the given pin level over a window.
	task duty(input int per, input logic l, output int c);
		c = 0;
		repeat (per) begin
			@(posedge clk_i);
			#1;
			if (timer_output_pin_o === l) c++;
		end
	endtask : duty

	// ****************************************************
	// Main sequence.
	// ****************************************************
	initial begin
		for (k = 0; k < 8; k++) mdl[k] = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		for (k = 0; k < 8; k++) rd_chk(8'(k * 4));
		wr(OFS_CTRL_A, 8'hFF);
		rd_chk(OFS_CTRL_A);
		wr(OFS_CTRL_A, 8'h00);
		for (k = 0; k < 4; k++) begin
			wr(OFS_CTRL_B, 8'($random(seed)));
			rd_chk(OFS_CTRL_B);
			wr(OFS_PERIOD, 8'($random(seed)));
			rd_chk(OFS_PERIOD);
		end
		wb(1'b1, OFS_PERIOD, 8'h5A, 4'h0);
		rd_chk(OFS_PERIOD);
		wr(OFS_CNT_HI, 8'h55);
		rdcnt();
		cmp_val("counter", 0, cv);
		// Low write is buffered: the high read must overwrite the buffer.
		wr(OFS_CMPA_LO, 8'($random(seed)));
		rd_chk(OFS_CMPA_HI);
		rd_chk(OFS_CMPA_LO);
		wr(OFS_CMPA_LO, 8'($random(seed)));
		wr(OFS_CMPA_HI, 8'($random(seed)));
		rd_chk(OFS_CMPA_HI);
		rd_chk(OFS_CMPA_LO);
		// Compare mode, clear on A, toggle from a high start.
		wr(OFS_CTRL_A, 8'h00);
		n = 16 + ($random(seed) & 63);
		wr(OFS_CMPA_LO, 8'(n));
		wr(OFS_CMPA_HI, 8'h00);
		wr(OFS_CTRL_B, 8'h39);
		wr(OFS_CTRL_A, 8'h18);
		ticks(2);
		cmp_bit("oe", 1'b1, timer_output_oe_o);
		cmp_bit("initial", 1'b1, timer_output_pin_o);
		k = p_cnt;
		gap(0, m);
		cmp_val("a_period", n, m);
		cmp_val("p_pulses", k, p_cnt);
		// Every pin function from a high initial level.
		for (k = 0; k < 4; k++) begin
			wr(OFS_CTRL_A, 8'h00);
			wr(OFS_CTRL_B, 8'h09 | 8'(k << 4));
			wr(OFS_CTRL_A, 8'h18);
			wait_flag(0);
			ticks(2);
			cmp_bit("match", k[0] ? 1'b0 : 1'b1, timer_output_pin_o);
			if (k == 3) begin
				wait_flag(0);
				ticks(2);
				cmp_bit("toggle", 1'b1, timer_output_pin_o);
			end
		end
		// Clear on P: period is whole multiples of 256, both flags fire.
		wr(OFS_CTRL_A, 8'h00);
		wr(OFS_CTRL_B, 8'h00);
		wr(OFS_PERIOD, 8'h01);
		wr(OFS_CTRL_A, 8'h18);
		gap(1, m);
		cmp_val("p_period", 256, m);
		gap(0, m);
		cmp_val("a_period", 256, m);
		// Pause and off both hold; a new enable clears.
		for (k = 0; k < 2; k++) begin
			wr(OFS_CTRL_A, k ? 8'h10 : 8'h98);
			rdcnt();
			n = cv;
			ticks(20);
			rdcnt();
			cmp_val("held", n, cv);
			cmp_val("high_byte", 0, cv[15:8]);
			wr(OFS_CTRL_A, 8'h18);
		end
		rdcnt();
		cmp_bit("cleared", 1'b1, cv < 16);
		// External edges, rising then falling.
		for (k = 0; k < 2; k++) begin
			wr(OFS_CTRL_A, 8'h00);
			wr(OFS_CTRL_B, 8'hC0);
			wr(OFS_CTRL_A, k ? 8'h78 : 8'h68);
			n = 3 + ($random(seed) & 7);
			repeat (2 * n) begin
				@(posedge clk_i);
				external_clock_pin_i <= ~external_clock_pin_i;
				ticks(3);
			end
			ticks(6);
			rdcnt();
			cmp_val("ext_count", n, cv);
			cmp_bit("oe_timer", 1'b0, timer_output_oe_o);
		end
		// Internal sources: two ticks of each between A matches.
		wr(OFS_CTRL_A, 8'h00);
		wr(OFS_CMPA_LO, 8'h02);
		wr(OFS_CMPA_HI, 8'h00);
		wr(OFS_CTRL_B, 8'h01);
		for (k = 0; k < 6; k++) begin
			wr(OFS_CTRL_A, 8'h08 | 8'(k << 4));
			gap(0, m);
			n = (k == 0) ? 4 : (k == 2) ? 16 : (k == 3) ? 64 : SUB_DIV;
			if (k == 1) n = 1;
			cmp_val("src_period", 2 * n, m);
			wr(OFS_CTRL_A, 8'h00);
		end
		// Zero P: no clear at 256 and no P request before wrap.
		wr(OFS_PERIOD, 8'h00);
		wr(OFS_CTRL_B, 8'h00);
		wr(OFS_CTRL_A, 8'h18);
		k = p_cnt;
		ticks(300);
		rdcnt();
		cmp_bit("p_zero_run", 1'b1, cv > 16'h0100);
		cmp_val("p_pulses", k, p_cnt);
		// Undefined mode code leaves the pin undriven.
		wr(OFS_CTRL_A, 8'h00);
		wr(OFS_PERIOD, 8'h01);
		wr(OFS_CTRL_B, 8'h40);
		wr(OFS_CTRL_A, 8'h18);
		ticks(2);
		cmp_bit("oe_undef", 1'b0, timer_output_oe_o);
		// PWM forced levels under each initial level and invert.
		for (k = 0; k < 8; k++) begin
			kb = 3'(k);
			wr(OFS_CTRL_A, 8'h00);
			wr(OFS_CTRL_B, 8'h80 | 8'(k << 2));
			wr(OFS_CTRL_A, 8'h18);
			ticks(3);
			lv = (kb[2] ? kb[1] : ~kb[1]) ^ kb[0];
			cmp_bit("pwm_level", lv, timer_output_pin_o);
		end
		// Waveform: duty from A, then with the roles swapped.
		for (k = 0; k < 2; k++) begin
			wr(OFS_CTRL_A, 8'h00);
			wr(OFS_CMPA_LO, k ? 8'h00 : 8'h40);
			wr(OFS_CMPA_HI, k ? 8'h03 : 8'h00);
			wr(OFS_CTRL_B, k ? 8'hAA : 8'hA8);
			wr(OFS_CTRL_A, 8'h18);
			ticks(4);
			duty(k ? 768 : 256, 1'b1, m);
			cmp_val("duty", k ? 256 : 64, m);
		end
		finish_test();
	end

endmodule : compact_timer_pwm_tb
